// >>> design/bhr_defines.svh
// register addresses, field positions and reset values of the history recorder
`ifndef BHR_DEFINES_SVH
`define BHR_DEFINES_SVH
`define BHR_ADDR_CTRL 12'h1d9
`define BHR_ADDR_TOP 12'h1c9
`define BHR_ADDR_REC0 12'h040
`define BHR_ADDR_REC7 12'h047
`define BHR_ADDR_EXC_SRC 12'h1dd
`define BHR_ADDR_EXC_DST 12'h1de
`define BHR_BIT_REC_EN 0
`define BHR_BIT_STEP_JMP 1
`define BHR_BIT_PIN_LO 2
`define BHR_BIT_MSG_EN 6
`define BHR_BIT_LOG_EN 7
`define BHR_BIT_IRQ_EN 8
`define BHR_CTRL_MASK 64'h0000_0000_0000_01ff
`define BHR_CTRL_RST 64'h0000_0000_0000_0000
`define BHR_DEPTH 8
`define BHR_LOG_DEPTH 16
`endif

// >>> design/bhr_pkg.sv
// types of the branch history recorder
package bhr_pkg;
	typedef struct packed {
		logic [31:0] dst;
		logic [31:0] src;
	} bhr_rec_t;

	typedef struct packed {
		logic valid;
		logic is_branch;
		logic trap_after;
		logic dbg_exc;
		bhr_rec_t rec;
		bhr_rec_t exc_rec;
	} bhr_event_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [63:0] wdata;
	} bhr_regreq_t;

	typedef enum logic {
		BHR_IDLE,
		BHR_SECOND
	} bhr_state_t;

	typedef struct packed {
		bhr_state_t st;
		bhr_rec_t pend;
		logic [63:0] ctrl;
		logic [2:0] top;
		logic [7:0][63:0] hist;
		bhr_rec_t exc;
		logic [63:0] rdata;
		logic rvalid;
		logic msg_valid;
		bhr_rec_t msg;
		logic log_wr;
		logic [3:0] log_idx;
		logic [63:0] log_data;
		logic log_full;
		logic log_irq;
		logic [3:0] pin_n;
		logic step_jmp;
	} bhr_state_all_t;
endpackage : bhr_pkg

// >>> design/bhr_recorder.sv
// branch history recorder: history stack, exception record, debug control
`timescale 1ns/1ns
`include "bhr_defines.svh"
module bhr_recorder
	import bhr_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire bhr_event_t i_event,
	input wire bhr_regreq_t i_reg,
	input wire logic [3:0] i_bp_match,
	input wire logic [3:0] i_perf_evt,
	output logic [63:0] o_rdata,
	output logic o_rvalid,
	output logic o_msg_valid,
	output bhr_rec_t o_msg,
	output logic o_log_wr,
	output logic [3:0] o_log_idx,
	output logic [63:0] o_log_data,
	output logic o_log_irq,
	output logic [3:0] o_bp_pin_n,
	output logic o_step_on_jumps
);
	bhr_state_all_t s_q;
	bhr_state_all_t s_d;

	logic rec_en;
	logic push;
	bhr_rec_t push_rec;
	logic [2:0] top_nx;

	assign rec_en = s_q.ctrl[`BHR_BIT_REC_EN];

	always_comb begin
		s_d = s_q;
		push = 1'b0;
		push_rec = i_event.rec;
		s_d.rvalid = 1'b0;
		s_d.msg_valid = 1'b0;
		s_d.log_wr = 1'b0;
		s_d.log_irq = 1'b0;
		// second half of a trapping jump: exception record follows
		case (s_q.st)
			BHR_SECOND: begin
				push = 1'b1;
				push_rec = s_q.pend;
				s_d.st = BHR_IDLE;
			end
			BHR_IDLE: begin
				if (i_event.valid) begin
					push = 1'b1;
					if (!i_event.is_branch) begin
						s_d.exc = s_q.hist[s_q.top];
					end
					if (i_event.trap_after) begin
						s_d.pend = i_event.exc_rec;
						s_d.st = BHR_SECOND;
					end
				end
			end
			default: s_d.st = BHR_IDLE;
		endcase
		top_nx = 3'(s_q.top + 3'h1);
		if (push && rec_en) begin
			s_d.top = top_nx;
			s_d.hist[top_nx] = push_rec;
		end
		if (push && s_q.st == BHR_SECOND && rec_en) begin
			s_d.exc = s_q.hist[top_nx - 3'h1];
		end
		if (push && s_q.ctrl[`BHR_BIT_MSG_EN]) begin
			s_d.msg_valid = 1'b1;
			s_d.msg = push_rec;
		end
		if (push && s_q.ctrl[`BHR_BIT_LOG_EN]
			&& !(s_q.log_full && s_q.ctrl[`BHR_BIT_IRQ_EN])) begin
			s_d.log_wr = 1'b1;
			s_d.log_idx = 4'(s_q.log_idx + 4'h1);
			s_d.log_data = push_rec;
			if (s_q.log_idx == 4'(`BHR_LOG_DEPTH - 2)) begin
				s_d.log_full = 1'b1;
				s_d.log_irq = s_q.ctrl[`BHR_BIT_IRQ_EN];
			end
		end
		// register access; history and pointer ignore writes
		if (i_reg.wr && i_reg.addr == `BHR_ADDR_CTRL) begin
			s_d.ctrl = i_reg.wdata & `BHR_CTRL_MASK;
			s_d.log_full = 1'b0;
			s_d.log_idx = 4'hf;
		end
		// debug exception wins over a same-cycle write of the enable
		if (i_event.valid && i_event.dbg_exc) begin
			s_d.ctrl[`BHR_BIT_REC_EN] = 1'b0;
		end
		if (i_reg.rd) begin
			s_d.rvalid = 1'b1;
			if (i_reg.addr == `BHR_ADDR_CTRL) begin
				s_d.rdata = s_q.ctrl;
			end else if (i_reg.addr == `BHR_ADDR_TOP) begin
				s_d.rdata = {61'h0, s_q.top};
			end else if (i_reg.addr >= `BHR_ADDR_REC0
				&& i_reg.addr <= `BHR_ADDR_REC7) begin
				s_d.rdata = s_q.hist[i_reg.addr[2:0]];
			end else if (i_reg.addr == `BHR_ADDR_EXC_SRC) begin
				s_d.rdata = {32'h0, s_q.exc.src};
			end else if (i_reg.addr == `BHR_ADDR_EXC_DST) begin
				s_d.rdata = {32'h0, s_q.exc.dst};
			end else begin
				s_d.rdata = 64'h0;
			end
		end
		for (int i = 0; i < 4; i++) begin
			if (s_q.ctrl[`BHR_BIT_PIN_LO + i]) begin
				s_d.pin_n[i] = ~i_bp_match[i];
			end else begin
				s_d.pin_n[i] = ~i_perf_evt[i];
			end
		end
		s_d.step_jmp = s_d.ctrl[`BHR_BIT_STEP_JMP];
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= '0;
			s_q.st <= BHR_IDLE;
			s_q.ctrl <= `BHR_CTRL_RST;
			s_q.log_idx <= 4'hf;
			s_q.pin_n <= 4'hf;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_rdata = s_q.rdata;
	assign o_rvalid = s_q.rvalid;
	assign o_msg_valid = s_q.msg_valid;
	assign o_msg = s_q.msg;
	assign o_log_wr = s_q.log_wr;
	assign o_log_idx = s_q.log_idx;
	assign o_log_data = s_q.log_data;
	assign o_log_irq = s_q.log_irq;
	assign o_bp_pin_n = s_q.pin_n;
	assign o_step_on_jumps = s_q.step_jmp;

	property p_push_top;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_event.valid && s_q.st == BHR_IDLE && rec_en)
			|=> s_q.top == 3'($past(s_q.top) + 3'h1);
	endproperty
	a_push_top: assert property (p_push_top)
		else $error("top pointer did not advance on push");

	property p_hist_write;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_event.valid && s_q.st == BHR_IDLE && rec_en)
			|=> s_q.hist[s_q.top] == $past(i_event.rec);
	endproperty
	a_hist_write: assert property (p_hist_write)
		else $error("record not stored at new top");

	property p_no_rec;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(!rec_en && !(i_reg.wr && i_reg.addr == `BHR_ADDR_CTRL))
			|=> $stable(s_q.top);
	endproperty
	a_no_rec: assert property (p_no_rec)
		else $error("pointer moved while recording off");

	property p_dbg_clear;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_event.valid && i_event.dbg_exc) |=> !rec_en;
	endproperty
	a_dbg_clear: assert property (p_dbg_clear)
		else $error("debug exception left recording on");

	property p_trap_two;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_event.valid && i_event.trap_after && s_q.st == BHR_IDLE
			&& rec_en && !i_event.dbg_exc)
			|=> ##1 s_q.hist[s_q.top] == $past(i_event.exc_rec, 2);
	endproperty
	a_trap_two: assert property (p_trap_two)
		else $error("exception record of trapping jump missing");

	property p_msg;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_event.valid && s_q.st == BHR_IDLE && s_q.ctrl[`BHR_BIT_MSG_EN])
			|=> o_msg_valid && o_msg == $past(i_event.rec);
	endproperty
	a_msg: assert property (p_msg)
		else $error("trace message not sent");

	property p_pin;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(s_q.ctrl[`BHR_BIT_PIN_LO] && i_bp_match[0]
			&& !(i_reg.wr && i_reg.addr == `BHR_ADDR_CTRL))
			|=> !o_bp_pin_n[0];
	endproperty
	a_pin: assert property (p_pin)
		else $error("breakpoint pin not asserted on match");

	property p_ro_top;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_reg.rd && i_reg.addr == `BHR_ADDR_TOP)
			|=> o_rvalid && o_rdata[63:3] == 61'h0;
	endproperty
	a_ro_top: assert property (p_ro_top)
		else $error("top pointer read wrong");

	c_trap: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_event.valid && i_event.trap_after && rec_en);
	c_irq: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_log_irq);
	c_wrap: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		s_q.top == 3'h7 ##1 s_q.top == 3'h0);
	c_pin_pulse: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!o_bp_pin_n[0] ##1 o_bp_pin_n[0]);
	c_ro_write: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_reg.wr && i_reg.addr == `BHR_ADDR_TOP);

	// log buffer: stop when full with interrupt on, wrap otherwise
	property p_log_stop;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(s_q.log_full && s_q.ctrl[`BHR_BIT_IRQ_EN]
			&& !(i_reg.wr && i_reg.addr == `BHR_ADDR_CTRL))
			|=> !o_log_wr;
	endproperty
	a_log_stop: assert property (p_log_stop)
		else $error("log written while full with interrupt on");

	property p_log_idx;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_event.valid && s_q.st == BHR_IDLE
			&& s_q.ctrl[`BHR_BIT_LOG_EN] && !s_q.ctrl[`BHR_BIT_IRQ_EN]
			&& !(i_reg.wr && i_reg.addr == `BHR_ADDR_CTRL))
			|=> o_log_wr && o_log_idx == 4'($past(o_log_idx) + 4'h1);
	endproperty
	a_log_idx: assert property (p_log_idx)
		else $error("log index did not advance circularly");

	property p_irq_pulse;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		o_log_irq |-> o_log_wr && o_log_idx == 4'hf;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("log interrupt without the filling write");

	property p_step;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_reg.wr && i_reg.addr == `BHR_ADDR_CTRL)
			|=> o_step_on_jumps == $past(i_reg.wdata[1]);
	endproperty
	a_step: assert property (p_step)
		else $error("step on jumps does not follow control");

	property p_pin_perf;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(!s_q.ctrl[`BHR_BIT_PIN_LO + 1]
			&& !(i_reg.wr && i_reg.addr == `BHR_ADDR_CTRL))
			|=> o_bp_pin_n[1] == !$past(i_perf_evt[1]);
	endproperty
	a_pin_perf: assert property (p_pin_perf)
		else $error("unselected pin does not carry its event");

	// the exception pair takes the newest record before it is covered
	property p_exc_copy;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_event.valid && !i_event.is_branch && s_q.st == BHR_IDLE)
			|=> s_q.exc == $past(s_q.hist[s_q.top]);
	endproperty
	a_exc_copy: assert property (p_exc_copy)
		else $error("exception record not copied");

	property p_ro_rec;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_reg.wr && i_reg.addr >= `BHR_ADDR_REC0
			&& i_reg.addr <= `BHR_ADDR_REC7
			&& !i_event.valid && s_q.st == BHR_IDLE)
			|=> $stable(s_q.hist);
	endproperty
	a_ro_rec: assert property (p_ro_rec)
		else $error("history record changed by a write");

	property p_ctrl_hi;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		1'b1 |-> s_q.ctrl[63:9] == 55'h0;
	endproperty
	a_ctrl_hi: assert property (p_ctrl_hi)
		else $error("unused control bits set");

	// a second event is never merged into the exception half
	property p_trap_idle;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		s_q.st == BHR_SECOND |=> s_q.st == BHR_IDLE;
	endproperty
	a_trap_idle: assert property (p_trap_idle)
		else $error("trap sequence did not return to idle");

	property p_rvalid;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		1'b1 |=> o_rvalid == $past(i_reg.rd);
	endproperty
	a_rvalid: assert property (p_rvalid)
		else $error("read valid does not follow the request");

	property p_rec_read;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_reg.rd && i_reg.addr == `BHR_ADDR_REC0)
			|=> o_rdata == $past(s_q.hist[0]);
	endproperty
	a_rec_read: assert property (p_rec_read)
		else $error("lowest record address does not read entry zero");
endmodule : bhr_recorder

// >>> tb/bhr_msg_sink.sv
// system bus side that takes in jump trace messages
`timescale 1ns/1ns
module bhr_msg_sink
	import bhr_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_msg_valid,
	input wire bhr_rec_t i_msg,
	output int o_count,
	output bhr_rec_t o_last
);
	initial o_count = 0;
	// the bus never stalls a message, so every pulse is counted
	always @(posedge i_clk_sys) begin
		if (i_msg_valid === 1'b1) begin
			o_count <= o_count + 1;
			o_last <= i_msg;
		end
	end
endmodule : bhr_msg_sink

// >>> tb/branch_history_recorder_tb.sv
// self-checking bench of the branch history recorder
`timescale 1ns/1ns
`include "bhr_defines.svh"
module branch_history_recorder_tb
	import bhr_pkg::*;
;
	logic i_clk_sys, i_rst_n, rv, mv, lw, irq, stp;
	bhr_event_t ev;
	bhr_regreq_t rq;
	logic [3:0] bp, perf, lidx, pin_n;
	logic [63:0] rdata, ldata;
	bhr_rec_t msg, mlast;
	int n_mismatch = 0, n_tests = 0, cyc = 0, mcnt;
	bhr_recorder i_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
		.i_event(ev), .i_reg(rq), .i_bp_match(bp), .i_perf_evt(perf),
		.o_rdata(rdata), .o_rvalid(rv), .o_msg_valid(mv), .o_msg(msg),
		.o_log_wr(lw), .o_log_idx(lidx), .o_log_data(ldata),
		.o_log_irq(irq), .o_bp_pin_n(pin_n), .o_step_on_jumps(stp));
	bhr_msg_sink i_sink (.i_clk_sys(i_clk_sys), .i_msg_valid(mv),
		.i_msg(msg), .o_count(mcnt), .o_last(mlast));
	initial begin
		i_clk_sys = 1'b0;
		forever #2 i_clk_sys = ~i_clk_sys;
	end
	task tally_and_finish;
		if (n_mismatch == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	// the whole run needs under two hundred cycles
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	task chk(input string nm, input logic [63:0] s, input logic [63:0] e);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task wr(input logic [11:0] a, input logic [63:0] d);
		@(posedge i_clk_sys);
		rq <= '{1'b1, 1'b0, a, d};
		@(posedge i_clk_sys);
		rq.wr <= 1'b0;
	endtask : wr
	task rd(input logic [11:0] a, input logic [63:0] e, input string nm);
		@(posedge i_clk_sys);
		rq <= '{1'b0, 1'b1, a, 64'h0};
		@(posedge i_clk_sys);
		rq.rd <= 1'b0;
		@(negedge i_clk_sys);
		chk(nm, rdata, e);
		chk("rvalid", {63'h0, rv}, 64'h1);
	endtask : rd
	// outputs of the push are looked at in the cycle they stand
	task push(input logic br, input logic dbg, input logic [63:0] r);
		@(posedge i_clk_sys);
		ev <= '{1'b1, br, 1'b0, dbg, r, 64'h0};
		@(posedge i_clk_sys);
		ev.valid <= 1'b0;
		@(negedge i_clk_sys);
	endtask : push
	task t_reset;
		rd(`BHR_ADDR_CTRL, 64'h0, "ctrl");
		chk("pins", 64'(pin_n), 64'hf);
	endtask : t_reset
	task t_record;
		wr(`BHR_ADDR_CTRL, 64'hc1);
		push(1'b1, 1'b0, 64'h2222_0000_1111_0000);
		chk("msg", {63'h0, mv}, 64'h1);
		chk("log", {59'h0, lw, lidx}, 64'h10);
		chk("logdata", ldata, 64'h2222_0000_1111_0000);
		rd(`BHR_ADDR_TOP, 64'h1, "top");
		rd(12'h041, 64'h2222_0000_1111_0000, "rec1");
		chk("sink", 64'(mcnt), 64'h1);
		chk("sinkrec", mlast, 64'h2222_0000_1111_0000);
	endtask : t_record
	task t_wrap;
		for (int i = 0; i < 7; i++)
			push(1'b1, 1'b0, 64'(i));
		rd(`BHR_ADDR_TOP, 64'h0, "wrap");
		rd(`BHR_ADDR_REC7, 64'h5, "rec7");
		wr(`BHR_ADDR_REC7, 64'h9);
		rd(`BHR_ADDR_REC7, 64'h5, "rec_ro");
		wr(`BHR_ADDR_TOP, 64'h5);
		rd(`BHR_ADDR_TOP, 64'h0, "ro");
		rd(12'h100, 64'h0, "unmapped");
	endtask : t_wrap
	task t_exc;
		push(1'b0, 1'b0, 64'h3333_0000_4444_0000);
		rd(`BHR_ADDR_EXC_SRC, 64'h6, "excsrc");
		rd(`BHR_ADDR_EXC_DST, 64'h0, "excdst");
		rd(`BHR_ADDR_REC0, 64'h6, "rec0");
		push(1'b0, 1'b1, 64'h0);
		rd(`BHR_ADDR_CTRL, 64'hc0, "dbgexc");
	endtask : t_exc
	task t_pins;
		wr(`BHR_ADDR_CTRL, 64'h06);
		@(negedge i_clk_sys);
		chk("step", {63'h0, stp}, 64'h1);
		@(posedge i_clk_sys);
		bp <= 4'h1;
		perf <= 4'ha;
		@(posedge i_clk_sys);
		bp <= 4'h0;
		@(negedge i_clk_sys);
		chk("pin_on", 64'(pin_n), 64'h4);
		@(negedge i_clk_sys);
		chk("pin_off", 64'(pin_n), 64'h5);
	endtask : t_pins
	// a trapping jump is followed by one idle event cycle
	task t_trap;
		wr(`BHR_ADDR_CTRL, 64'h01);
		@(posedge i_clk_sys);
		ev <= '{1'b1, 1'b1, 1'b1, 1'b0, 64'h5555_0000_6666_0000,
			64'h7777_0000_8888_0000};
		@(posedge i_clk_sys);
		ev.valid <= 1'b0;
		rd(`BHR_ADDR_TOP, 64'h4, "traptop");
		rd(12'h043, 64'h5555_0000_6666_0000, "trapjmp");
		rd(12'h044, 64'h7777_0000_8888_0000, "trapexc");
		rd(`BHR_ADDR_EXC_SRC, 64'h6666_0000, "trapsrc");
	endtask : t_trap
	task t_log;
		wr(`BHR_ADDR_CTRL, 64'h180);
		for (int i = 0; i < 16; i++)
			push(1'b1, 1'b0, 64'(i));
		chk("full", {58'h0, irq, lw, lidx}, 64'h3f);
		push(1'b1, 1'b0, 64'h0);
		chk("stop", {63'h0, lw}, 64'h0);
		wr(`BHR_ADDR_CTRL, 64'h080);
		for (int i = 0; i < 17; i++)
			push(1'b1, 1'b0, 64'(i));
		chk("logwrap", {58'h0, irq, lw, lidx}, 64'h10);
	endtask : t_log
	initial begin
		i_rst_n = 1'b0;
		ev = '0;
		rq = '0;
		bp = 4'h0;
		perf = 4'h0;
		repeat (2) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		t_reset();
		t_record();
		t_wrap();
		t_exc();
		t_pins();
		t_trap();
		t_log();
		tally_and_finish();
	end
endmodule : branch_history_recorder_tb
